/* File: src/pmusc_pkg.sv */
// Purpose: Constants shared by the system control register bank.
// Assumes: 8-bit register addresses and data, 125 MHz clock.
// Notes: Register offsets, field positions, reset values and delay counts.
package pmusc_pkg;
   // Register offsets.
   localparam logic [7:0] ADDR_BUTTON_WATCHDOG_CTRL = 8'h00_C0;
   localparam logic [7:0] ADDR_IRQ_SOURCE_ADDRESS = 8'h00_C1;
   localparam logic [7:0] ADDR_BUTTON_STATUS = 8'h00_C2;
   localparam logic [7:0] ADDR_SOFTWARE_POWER_CYCLE = 8'h00_C3;
   localparam logic [7:0] ADDR_RESET_CAUSE_FLAGS = 8'h00_C5;
   localparam logic [7:0] ADDR_PWM_CTRL_IO6 = 8'h00_E3;
   localparam logic [7:0] ADDR_PWM_CTRL_IO5 = 8'h00_E4;
   localparam logic [7:0] ADDR_PWM_CTRL_IO1 = 8'h00_E5;
   localparam logic [7:0] ADDR_PWM_CTRL_IO2 = 8'h00_F3;
   localparam logic [7:0] ADDR_PWM_CTRL_IO3 = 8'h00_F4;
   localparam logic [7:0] ADDR_PWM_CTRL_IO4 = 8'h00_F5;
   // Field positions.
   localparam int BIT_BUTTON_ASSERT_IRQ_ENABLE = 7;
   localparam int BIT_BUTTON_DEASSERT_IRQ_ENABLE = 6;
   localparam int BIT_WATCHDOG_SOFT_RESET_ENABLE = 1;
   localparam int BIT_WATCHDOG_POWER_CYCLE_ENABLE = 0;
   localparam int BIT_BUTTON_ASSERT_IRQ_STATUS = 7;
   localparam int BIT_BUTTON_DEASSERT_IRQ_STATUS = 6;
   localparam int BIT_BUTTON_LIVE = 5;
   localparam int BIT_SOFTWARE_POWER_CYCLE_REQUEST = 0;
   localparam int BIT_POWER_CYCLE_FLAG = 1;
   localparam int BIT_SOFT_RESET_FLAG = 0;
   localparam int BIT_PWM_ENABLE = 7;
   localparam int PWM_FREQ_MSB = 6;
   localparam int PWM_FREQ_LSB = 4;
   localparam int PWM_DUTY_MSB = 3;
   localparam int PWM_DUTY_LSB = 0;
   localparam int PWM_DUTY_W = 4;
   // Reset values.
   localparam logic [7:0] RST_IRQ_SOURCE_ADDRESS = 8'h00_FF;
   localparam logic [7:0] RST_ZERO = 8'h00_00;
   // Timing.
   localparam int CLK_PERIOD_NS = 8;
   localparam int SOFTWARE_POWER_CYCLE_DELAY_NS = 8_000_000;
   localparam int SOFTWARE_POWER_CYCLE_DELAY_CYCLES = (SOFTWARE_POWER_CYCLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PWM_BASE_CYCLES = 64;
endpackage : pmusc_pkg

/* File: src/pmusc_regs.sv */
// Purpose: System control register bank with watchdog, button, power cycle and PWM control.
// Assumes: The serial engine presents one-cycle read and write strobes on clk_i.
// Notes: Read data is returned one cycle after the read strobe.
`timescale 1ns/1ps
module pmusc_regs
   import pmusc_pkg::*;
#(
   parameter int SOFTWARE_POWER_CYCLE_DELAY = SOFTWARE_POWER_CYCLE_DELAY_CYCLES,
   parameter int PWM_BASE = PWM_BASE_CYCLES,
   parameter int PWM_CNT_W = 16
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Register port from the serial engine.
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // System events.
   input wire logic push_button_input_n_i,
   input wire logic watchdog_expire_i,
   input wire logic sleep_enter_i,
   input wire logic irq_source_valid_i,
   input wire logic [7:0] irq_source_i,
   input wire logic soft_reset_done_i,
   input wire logic power_cycle_done_i,
   // Sequencer requests and the button interrupt.
   output logic soft_reset_start_o,
   output logic power_cycle_start_o,
   output logic button_irq_o,
   // PWM outputs, index 0 is PWM_CTRL_IO1.
   output logic [5:0] pwm_enable_o,
   output logic [5:0] pwm_o
);
   localparam int SOFTWARE_POWER_CYCLE_W = $clog2(SOFTWARE_POWER_CYCLE_DELAY + 1);

   if (SOFTWARE_POWER_CYCLE_DELAY < 1) begin : g_chk_delay
      $error("SOFTWARE_POWER_CYCLE_DELAY must be at least one cycle");
   end
   if ((PWM_BASE < 16) || ((PWM_BASE * 128) >= (2 ** PWM_CNT_W))) begin : g_chk_pwm
      $error("PWM_BASE must be at least 16 and the longest period must fit PWM_CNT_W");
   end

   logic btn_meta_q;
   logic btn_sync_q;
   logic btn_prev_q;
   logic btn_live;
   logic btn_rise;
   logic btn_fall;
   logic [7:0] ctrl_q;
   logic [7:0] irq_src_q;
   logic assert_stat_q;
   logic deassert_stat_q;
   logic software_power_cycle_q;
   logic [SOFTWARE_POWER_CYCLE_W-1:0] software_power_cycle_cnt_q;
   logic software_power_cycle_fire;
   logic pc_flag_q;
   logic sr_flag_q;
   logic [7:0] pwm_reg_q [6];
   logic rd_src;
   logic rd_stat;
   logic rd_cause;
   logic wr_ctrl;
   logic wr_software_power_cycle;

   assign rd_src = reg_rd_i && (reg_addr_i == ADDR_IRQ_SOURCE_ADDRESS);
   assign rd_stat = reg_rd_i && (reg_addr_i == ADDR_BUTTON_STATUS);
   assign rd_cause = reg_rd_i && (reg_addr_i == ADDR_RESET_CAUSE_FLAGS);
   assign wr_ctrl = reg_wr_i && (reg_addr_i == ADDR_BUTTON_WATCHDOG_CTRL);
   assign wr_software_power_cycle = reg_wr_i && (reg_addr_i == ADDR_SOFTWARE_POWER_CYCLE);

   // Synchronise the active-low button pin and find its edges.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         btn_meta_q <= 1'b1;
         btn_sync_q <= 1'b1;
         btn_prev_q <= 1'b0;
      end else begin
         btn_meta_q <= push_button_input_n_i;
         btn_sync_q <= btn_meta_q;
         btn_prev_q <= btn_live;
      end
   end
   assign btn_live = ~btn_sync_q;
   assign btn_rise = btn_live && !btn_prev_q;
   assign btn_fall = !btn_live && btn_prev_q;

   // Control register; sleep entry wins over a write to the watchdog enables.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ctrl_q <= RST_ZERO;
      end else begin
         if (wr_ctrl) begin
            ctrl_q[BIT_BUTTON_ASSERT_IRQ_ENABLE] <= reg_wdata_i[BIT_BUTTON_ASSERT_IRQ_ENABLE];
            ctrl_q[BIT_BUTTON_DEASSERT_IRQ_ENABLE] <= reg_wdata_i[BIT_BUTTON_DEASSERT_IRQ_ENABLE];
            ctrl_q[BIT_WATCHDOG_SOFT_RESET_ENABLE] <= reg_wdata_i[BIT_WATCHDOG_SOFT_RESET_ENABLE];
            ctrl_q[BIT_WATCHDOG_POWER_CYCLE_ENABLE] <= reg_wdata_i[BIT_WATCHDOG_POWER_CYCLE_ENABLE];
         end
         if (sleep_enter_i) begin
            ctrl_q[BIT_WATCHDOG_SOFT_RESET_ENABLE] <= 1'b0;
            ctrl_q[BIT_WATCHDOG_POWER_CYCLE_ENABLE] <= 1'b0;
         end
      end
   end

   // Interrupt source address; a new source wins over the restore after read.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         irq_src_q <= RST_IRQ_SOURCE_ADDRESS;
      end else if (irq_source_valid_i) begin
         irq_src_q <= irq_source_i;
      end else if (rd_src) begin
         irq_src_q <= RST_IRQ_SOURCE_ADDRESS;
      end
   end

   // Sticky button interrupt status, cleared by reading the status register.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         assert_stat_q <= 1'b0;
         deassert_stat_q <= 1'b0;
      end else begin
         if (btn_rise && ctrl_q[BIT_BUTTON_ASSERT_IRQ_ENABLE]) begin
            assert_stat_q <= 1'b1;
         end else if (rd_stat) begin
            assert_stat_q <= 1'b0;
         end
         if (btn_fall && ctrl_q[BIT_BUTTON_DEASSERT_IRQ_ENABLE]) begin
            deassert_stat_q <= 1'b1;
         end else if (rd_stat) begin
            deassert_stat_q <= 1'b0;
         end
      end
   end

   // Software power cycle request and its delay counter.
   assign software_power_cycle_fire = software_power_cycle_q && (software_power_cycle_cnt_q == SOFTWARE_POWER_CYCLE_W'(SOFTWARE_POWER_CYCLE_DELAY - 1));
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         software_power_cycle_q <= 1'b0;
         software_power_cycle_cnt_q <= '0;
      end else if (software_power_cycle_fire) begin
         software_power_cycle_q <= 1'b0;
         software_power_cycle_cnt_q <= '0;
      end else if (software_power_cycle_q) begin
         software_power_cycle_cnt_q <= software_power_cycle_cnt_q + SOFTWARE_POWER_CYCLE_W'(1);
      end else if (wr_software_power_cycle && reg_wdata_i[BIT_SOFTWARE_POWER_CYCLE_REQUEST]) begin
         software_power_cycle_q <= 1'b1;
         software_power_cycle_cnt_q <= '0;
      end
   end

   // Sequencer start pulses.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         soft_reset_start_o <= 1'b0;
         power_cycle_start_o <= 1'b0;
      end else begin
         soft_reset_start_o <= watchdog_expire_i && ctrl_q[BIT_WATCHDOG_SOFT_RESET_ENABLE];
         power_cycle_start_o <= (watchdog_expire_i && ctrl_q[BIT_WATCHDOG_POWER_CYCLE_ENABLE])
            || software_power_cycle_fire;
      end
   end

   // Reset cause flags; a new event wins over the clear after read.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pc_flag_q <= 1'b0;
         sr_flag_q <= 1'b0;
      end else begin
         if (power_cycle_done_i) begin
            pc_flag_q <= 1'b1;
         end else if (rd_cause) begin
            pc_flag_q <= 1'b0;
         end
         if (soft_reset_done_i) begin
            sr_flag_q <= 1'b1;
         end else if (rd_cause) begin
            sr_flag_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         button_irq_o <= 1'b0;
      end else begin
         button_irq_o <= assert_stat_q || deassert_stat_q;
      end
   end

   // PWM control registers, index 0 to 5 for PWM_CTRL_IO1 to PWM_CTRL_IO6.
   localparam logic [7:0] PWM_ADDR [6] = '{ADDR_PWM_CTRL_IO1, ADDR_PWM_CTRL_IO2, ADDR_PWM_CTRL_IO3,
      ADDR_PWM_CTRL_IO4, ADDR_PWM_CTRL_IO5, ADDR_PWM_CTRL_IO6};

   for (genvar g = 0; g < 6; g++) begin : g_pwm
      logic [PWM_CNT_W-1:0] cnt_q;
      logic [PWM_CNT_W-1:0] period;
      logic [PWM_CNT_W-1:0] high;
      logic [PWM_CNT_W+PWM_DUTY_W-1:0] prod;

      always_ff @(posedge clk_i) begin
         if (sys_rst_i) begin
            pwm_reg_q[g] <= RST_ZERO;
         end else if (reg_wr_i && (reg_addr_i == PWM_ADDR[g])) begin
            pwm_reg_q[g] <= reg_wdata_i;
         end
      end

      // Period doubles per frequency code; high time is duty sixteenths of it.
      assign period = PWM_CNT_W'(PWM_BASE) << pwm_reg_q[g][PWM_FREQ_MSB:PWM_FREQ_LSB];
      assign prod = period * pwm_reg_q[g][PWM_DUTY_MSB:PWM_DUTY_LSB];
      assign high = prod[PWM_CNT_W+PWM_DUTY_W-1:PWM_DUTY_W];

      always_ff @(posedge clk_i) begin
         if (sys_rst_i || !pwm_reg_q[g][BIT_PWM_ENABLE]) begin
            cnt_q <= '0;
            pwm_o[g] <= 1'b0;
            pwm_enable_o[g] <= 1'b0;
         end else begin
            cnt_q <= (cnt_q >= period - PWM_CNT_W'(1)) ? '0 : cnt_q + PWM_CNT_W'(1);
            pwm_o[g] <= (cnt_q < high);
            pwm_enable_o[g] <= 1'b1;
         end
      end
   end

   // Read decode; reserved bits and unmapped addresses read zero.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= RST_ZERO;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;
         reg_rdata_o <= RST_ZERO;
         if (reg_addr_i == ADDR_BUTTON_WATCHDOG_CTRL) begin
            reg_rdata_o <= {ctrl_q[7:6], 4'h0, ctrl_q[1:0]};
         end else if (reg_addr_i == ADDR_IRQ_SOURCE_ADDRESS) begin
            reg_rdata_o <= irq_src_q;
         end else if (reg_addr_i == ADDR_BUTTON_STATUS) begin
            reg_rdata_o <= {assert_stat_q, deassert_stat_q, btn_live, 5'h00};
         end else if (reg_addr_i == ADDR_SOFTWARE_POWER_CYCLE) begin
            reg_rdata_o <= {7'h00, software_power_cycle_q};
         end else if (reg_addr_i == ADDR_RESET_CAUSE_FLAGS) begin
            reg_rdata_o <= {6'h00, pc_flag_q, sr_flag_q};
         end else begin
            for (int i = 0; i < 6; i++) begin
               if (reg_addr_i == PWM_ADDR[i]) begin
                  reg_rdata_o <= pwm_reg_q[i];
               end
            end
         end
      end
   end

   a_wd_soft: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      watchdog_expire_i && ctrl_q[BIT_WATCHDOG_SOFT_RESET_ENABLE] |=> soft_reset_start_o)
      else $error("watchdog soft reset not started");
   a_wd_cycle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      watchdog_expire_i && ctrl_q[BIT_WATCHDOG_POWER_CYCLE_ENABLE] |=> power_cycle_start_o)
      else $error("watchdog power cycle not started");
   a_sleep_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      sleep_enter_i |=> ctrl_q[1:0] == 2'b00)
      else $error("watchdog enables survive sleep");
   a_src_restore: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rd_src && !irq_source_valid_i |=> irq_src_q == RST_IRQ_SOURCE_ADDRESS)
      else $error("source address not restored after read");
   a_src_capture: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      irq_source_valid_i |=> irq_src_q == $past(irq_source_i))
      else $error("source address not captured");
   a_btn_assert: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      btn_rise && ctrl_q[BIT_BUTTON_ASSERT_IRQ_ENABLE] |=> assert_stat_q ##1 button_irq_o)
      else $error("button assert interrupt missing");
   a_btn_deassert: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      btn_fall && ctrl_q[BIT_BUTTON_DEASSERT_IRQ_ENABLE] |=> deassert_stat_q)
      else $error("button deassert interrupt missing");
   a_btn_live: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rd_stat |=> reg_rvalid_o && (reg_rdata_o[BIT_BUTTON_LIVE] == $past(btn_live)))
      else $error("live button bit wrong");
   a_software_power_cycle_delay: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      software_power_cycle_q && !software_power_cycle_fire && !watchdog_expire_i |=> software_power_cycle_q && !power_cycle_start_o)
      else $error("software power cycle fired early");
   a_cause_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rd_cause && !power_cycle_done_i && !soft_reset_done_i |=> !pc_flag_q && !sr_flag_q)
      else $error("reset cause flags not cleared by read");
   a_pwm_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !pwm_reg_q[0][BIT_PWM_ENABLE] |=> !pwm_o[0] && !pwm_enable_o[0])
      else $error("pwm active while disabled");
   a_software_power_cycle_fire: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      software_power_cycle_fire |=> power_cycle_start_o && !software_power_cycle_q)
      else $error("software power cycle not started");
   a_sr_flag_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      soft_reset_done_i |=> sr_flag_q)
      else $error("soft reset flag not set");
   a_pc_flag_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      power_cycle_done_i |=> pc_flag_q)
      else $error("power cycle flag not set");
   a_assert_stat_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rd_stat && !btn_rise |=> !assert_stat_q)
      else $error("assert status not cleared by read");
   a_deassert_stat_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rd_stat && !btn_fall |=> !deassert_stat_q)
      else $error("deassert status not cleared by read");
   a_pwm_on: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      pwm_reg_q[0][BIT_PWM_ENABLE] |=> pwm_enable_o[0])
      else $error("pwm function not enabled");
   a_duty_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      pwm_reg_q[1][PWM_DUTY_MSB:PWM_DUTY_LSB] == 4'h0 |=> !pwm_o[1])
      else $error("pwm high with zero duty");
   a_cause_reserved: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rd_cause |=> reg_rdata_o[7:2] == 6'h00)
      else $error("reserved cause bits not zero");
   a_ctrl_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_ctrl && !sleep_enter_i |=> ctrl_q == {$past(reg_wdata_i[7:6]), 4'h0, $past(reg_wdata_i[1:0])})
      else $error("control write wrong");
   a_src_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rd_src |=> reg_rdata_o == $past(irq_src_q))
      else $error("source address read wrong");
   a_pwm_readback: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      reg_rd_i && (reg_addr_i == ADDR_PWM_CTRL_IO1) |=> reg_rdata_o == $past(pwm_reg_q[0]))
      else $error("pwm register read wrong");
endmodule : pmusc_regs

/* File: verif/pmusc_seq_model.sv */
// Purpose: Reset and power sequencer model answering the bank's start requests.
// Assumes: Start requests are one-cycle pulses on clk_i.
// Notes: Each start is answered by a one-cycle done pulse DONE_LAT cycles later.
`timescale 1ns/1ps
module pmusc_seq_model #(
   parameter int DONE_LAT = 5
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Requests from the bank.
   input wire logic soft_reset_start_i,
   input wire logic power_cycle_start_i,
   // Completion pulses.
   output logic soft_reset_done_o,
   output logic power_cycle_done_o
);
   logic [DONE_LAT-1:0] sr_q;
   logic [DONE_LAT-1:0] pc_q;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         sr_q <= '0;
         pc_q <= '0;
      end else begin
         sr_q <= {sr_q[DONE_LAT-2:0], soft_reset_start_i};
         pc_q <= {pc_q[DONE_LAT-2:0], power_cycle_start_i};
      end
   end
   assign soft_reset_done_o = sr_q[DONE_LAT-1];
   assign power_cycle_done_o = pc_q[DONE_LAT-1];
endmodule : pmusc_seq_model

/* File: verif/tb.sv */
// Purpose: Self-checking bench for the system control register bank.
// Assumes: Strobe register port, short power-cycle delay and PWM base in simulation.
// Notes: Expected values follow the register map and the hand-over timing.
`timescale 1ns/1ps
module tb;
   import pmusc_pkg::*;
   localparam int SOFTWARE_POWER_CYCLE_SIM = 20;
   logic clk_i = 0;
   logic sys_rst_i = 1;
   logic [7:0] reg_addr_i = 8'h00_00;
   logic [7:0] reg_wdata_i = 8'h00_00;
   logic reg_wr_i = 0, reg_rd_i = 0, reg_rvalid_o;
   logic [7:0] reg_rdata_o;
   logic [7:0] src = 8'h00_00;
   logic btn_n = 1, wd_exp = 0, sleep = 0, src_v = 0;
   logic sr_done, pc_done, sr_start, pc_start, btn_irq;
   logic [5:0] pwm_en, pwm;
   logic [7:0] addrs [6] = '{8'h00_E5, 8'h00_F3, 8'h00_F4, 8'h00_F5, 8'h00_E4, 8'h00_E3};
   logic [7:0] vals [6] = '{8'h00_88, 8'h00_90, 8'h00_A5, 8'h00_3C, 8'h00_F1, 8'h00_7F};
   int failures = 0, total_checks = 0, cyc = 0, sr_cnt = 0, pc_cnt = 0, n0, n1, n2;

   initial begin
      forever #4 clk_i = ~clk_i;
   end

   pmusc_regs #(.SOFTWARE_POWER_CYCLE_DELAY(SOFTWARE_POWER_CYCLE_SIM), .PWM_BASE(16)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .push_button_input_n_i(btn_n),
      .watchdog_expire_i(wd_exp), .sleep_enter_i(sleep), .irq_source_valid_i(src_v),
      .irq_source_i(src), .soft_reset_done_i(sr_done), .power_cycle_done_i(pc_done),
      .soft_reset_start_o(sr_start), .power_cycle_start_o(pc_start), .button_irq_o(btn_irq),
      .pwm_enable_o(pwm_en), .pwm_o(pwm));

   pmusc_seq_model seq (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_reset_start_i(sr_start),
      .power_cycle_start_i(pc_start), .soft_reset_done_o(sr_done), .power_cycle_done_o(pc_done));

   task close_out;
      if (failures == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out

   task chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1;
      @(posedge clk_i);
      reg_wr_i <= 0;
   endtask : wr

   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1;
      @(posedge clk_i);
      reg_rd_i <= 0;
      #1;
      chk({7'h00, reg_rvalid_o}, 8'h00_01);
      chk(reg_rdata_o, exp);
   endtask : rd

   task wd_pulse;
      @(posedge clk_i);
      wd_exp <= 1;
      @(posedge clk_i);
      wd_exp <= 0;
   endtask : wd_pulse

   task btn(input logic lvl);
      @(posedge clk_i);
      btn_n <= lvl;
      repeat (8) @(posedge clk_i);
   endtask : btn

   always @(posedge clk_i) begin
      cyc++;
      if (sr_start === 1'b1) sr_cnt++;
      if (pc_start === 1'b1) pc_cnt++;
      if (cyc == 5000) begin
         failures++;
         close_out;
      end
   end

   initial begin
      repeat (3) @(posedge clk_i);
      sys_rst_i <= 0;
      rd(ADDR_IRQ_SOURCE_ADDRESS, 8'h00_FF);
      rd(ADDR_BUTTON_WATCHDOG_CTRL, 8'h00_00);
      rd(8'h00_10, 8'h00_00);
      @(posedge clk_i);
      src <= 8'h00_5A;
      src_v <= 1;
      @(posedge clk_i);
      src_v <= 0;
      rd(ADDR_IRQ_SOURCE_ADDRESS, 8'h00_5A);
      rd(ADDR_IRQ_SOURCE_ADDRESS, 8'h00_FF);
      wr(ADDR_BUTTON_WATCHDOG_CTRL, 8'h00_FE);
      rd(ADDR_BUTTON_WATCHDOG_CTRL, 8'h00_C2);
      wd_pulse;
      repeat (10) @(posedge clk_i);
      chk(8'(sr_cnt), 8'h00_01);
      chk(8'(pc_cnt), 8'h00_00);
      rd(ADDR_RESET_CAUSE_FLAGS, 8'h00_01);
      rd(ADDR_RESET_CAUSE_FLAGS, 8'h00_00);
      wr(ADDR_BUTTON_WATCHDOG_CTRL, 8'h00_C1);
      wd_pulse;
      repeat (10) @(posedge clk_i);
      chk(8'(pc_cnt), 8'h00_01);
      chk(8'(sr_cnt), 8'h00_01);
      rd(ADDR_RESET_CAUSE_FLAGS, 8'h00_02);
      rd(ADDR_RESET_CAUSE_FLAGS, 8'h00_00);
      @(posedge clk_i);
      sleep <= 1;
      @(posedge clk_i);
      sleep <= 0;
      rd(ADDR_BUTTON_WATCHDOG_CTRL, 8'h00_C0);
      btn(0);
      chk({7'h00, btn_irq}, 8'h00_01);
      rd(ADDR_BUTTON_STATUS, 8'h00_A0);
      rd(ADDR_BUTTON_STATUS, 8'h00_20);
      chk({7'h00, btn_irq}, 8'h00_00);
      btn(1);
      rd(ADDR_BUTTON_STATUS, 8'h00_40);
      wr(ADDR_BUTTON_STATUS, 8'h00_FF);
      rd(ADDR_BUTTON_STATUS, 8'h00_00);
      wr(ADDR_BUTTON_WATCHDOG_CTRL, 8'h00_00);
      btn(0);
      rd(ADDR_BUTTON_STATUS, 8'h00_20);
      btn(1);
      rd(ADDR_BUTTON_STATUS, 8'h00_00);
      wr(ADDR_SOFTWARE_POWER_CYCLE, 8'h00_01);
      rd(ADDR_SOFTWARE_POWER_CYCLE, 8'h00_01);
      repeat (SOFTWARE_POWER_CYCLE_SIM - 3) @(posedge clk_i);
      #1;
      chk({7'h00, pc_start}, 8'h00_00);
      @(posedge clk_i);
      #1;
      chk({7'h00, pc_start}, 8'h00_01);
      chk(8'(pc_cnt), 8'h00_01);
      repeat (10) @(posedge clk_i);
      chk(8'(pc_cnt), 8'h00_02);
      rd(ADDR_SOFTWARE_POWER_CYCLE, 8'h00_00);
      rd(ADDR_RESET_CAUSE_FLAGS, 8'h00_02);
      for (int i = 0; i < 6; i++) wr(addrs[i], vals[i]);
      for (int i = 0; i < 6; i++) rd(addrs[i], vals[i]);
      chk({2'b00, pwm_en}, 8'h00_17);
      n0 = 0;
      n1 = 0;
      n2 = 0;
      repeat (64) begin
         @(posedge clk_i);
         #1;
         n0 += (pwm[0] === 1'b1);
         n1 += (pwm[1] === 1'b1);
         n2 += (pwm[2] === 1'b1);
      end
      chk(8'(n0), 8'h00_20);
      chk(8'(n1), 8'h00_00);
      chk(8'(n2), 8'h00_14);
      chk({2'b00, pwm & ~pwm_en}, 8'h00_00);
      wait (pwm[2] === 1'b0);
      wait (pwm[2] === 1'b1);
      n1 = 0;
      while (pwm[2] === 1'b1) begin
         @(posedge clk_i);
         #1;
         n1++;
      end
      while (pwm[2] !== 1'b1) begin
         @(posedge clk_i);
         #1;
         n1++;
      end
      chk(8'(n1), 8'h00_40);
      close_out;
   end
endmodule : tb
